// ===== hdl/ccpcmp_pkg.sv
// Summary of operation
// - compare the 16-bit value pair against the selected timer count without pause
// - on a match do the one action the mode field picks
// - set the match flag together with the match action in every compare mode; off mode never matches or sets it
// - software interrupt mode only raises the flag, pin stays free
// - trigger mode resets the timer, starts conversion if enabled, pin stays free
// - trigger output at once, timer reset at next timer clock edge
// - a trigger timer reset never sets the timer overflow flag
// - match removed before the timer edge cancels the timer reset
// - writing zero to the control register drives the output latch low
// - units 1-5 use timer one or three, units 6-10 one or five
// - compare needs the system clock and does nothing in sleep
package ccpcmp_pkg;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 3;
  localparam int MODE_W = 4;
  // ==========================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CMP_LO = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CMP_HI = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_TSEL = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 3'h5;
  // ==========================================
  // fields and reset values
  localparam int STAT_MATCH = 0;
  localparam int TSEL_ALT = 0;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  // ==========================================
  // mode field codes
  localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
  localparam logic [MODE_W-1:0] MODE_TOGGLE = 4'h2;
  localparam logic [MODE_W-1:0] MODE_SET = 4'h8;
  localparam logic [MODE_W-1:0] MODE_CLEAR = 4'h9;
  localparam logic [MODE_W-1:0] MODE_SWINT = 4'ha;
  localparam logic [MODE_W-1:0] MODE_SPECIAL = 4'hb;
  // ==========================================
  // unit numbering and time base split
  localparam int UNIT_MIN = 1;
  localparam int UNIT_MAX = 10;
  localparam int UNIT_LAST_B = 5;
endpackage : ccpcmp_pkg

// ===== hdl/ccpcmp_top.sv
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module ccpcmp_top #(
  parameter int UNIT_INDEX = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [ccpcmp_pkg::ADDR_W-1:0] addr,
  input wire logic [ccpcmp_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ccpcmp_pkg::DATA_W-1:0] rdata,
  // timer one
  input wire logic [ccpcmp_pkg::CNT_W-1:0] timer_a_count,
  input wire logic timer_a_tick,
  output logic timer_a_reset,
  // timer three or five
  input wire logic [ccpcmp_pkg::CNT_W-1:0] timer_alt_count,
  input wire logic timer_alt_tick,
  output logic timer_alt_reset,
  // converter
  input wire logic adc_enable,
  output logic adc_start,
  // power state
  input wire logic sleep_mode,
  // pin and events
  output logic compare_pin_out,
  output logic compare_pin_oe,
  output logic special_trigger,
  output logic irq
);

  // ==========================================
  // parameter check
  // alt timer is three for low units, five for high units
  if (UNIT_INDEX < ccpcmp_pkg::UNIT_MIN || UNIT_INDEX > ccpcmp_pkg::UNIT_MAX) begin : g_bad_unit
    $error("unit index out of range");
  end
  // compare value is written as two bus bytes
  if (ccpcmp_pkg::CNT_W != 2 * ccpcmp_pkg::DATA_W) begin : g_bad_width
    $error("compare width must be two bus bytes");
  end

  // ==========================================
  // state
  logic [ccpcmp_pkg::MODE_W-1:0] ctrl_q, ctrl_d;
  logic [ccpcmp_pkg::CNT_W-1:0] cmp_q, cmp_d;
  logic tsel_q, tsel_d;
  logic stat_q, stat_d;
  logic mask_q, mask_d;
  logic match_q, match_d;
  logic pend_q, pend_d;
  logic pin_q, pin_d;
  logic oe_q, oe_d;
  logic trig_q, trig_d;
  logic adc_q, adc_d;
  logic rsta_q, rsta_d;
  logic rstb_q, rstb_d;
  logic irq_q, irq_d;
  logic [ccpcmp_pkg::DATA_W-1:0] rdata_q, rdata_d;

  logic [ccpcmp_pkg::CNT_W-1:0] sel_cnt;
  logic sel_tick;
  logic mode_cmp;
  logic match_now;
  logic match_edge;
  logic ctrl_wr;
  logic do_reset;

  // ==========================================
  // compare path
  always_comb begin
    sel_cnt = tsel_q ? timer_alt_count : timer_a_count;
    sel_tick = tsel_q ? timer_alt_tick : timer_a_tick;
    unique case (ctrl_q)
      ccpcmp_pkg::MODE_TOGGLE,
      ccpcmp_pkg::MODE_SET,
      ccpcmp_pkg::MODE_CLEAR,
      ccpcmp_pkg::MODE_SWINT,
      ccpcmp_pkg::MODE_SPECIAL: mode_cmp = 1'b1;
      default: mode_cmp = 1'b0;
    endcase
    // no system clock in sleep, so no compare there
    match_now = mode_cmp && !sleep_mode && (cmp_q == sel_cnt);
    // timer holds a count for many cycles: act once per match
    match_edge = match_now && !match_q;
    ctrl_wr = wr && (addr == ccpcmp_pkg::ADDR_CTRL);
    // reset only if the match still stands at the timer edge
    do_reset = pend_q && sel_tick && match_now;
  end

  // ==========================================
  // next state
  always_comb begin
    ctrl_d = ctrl_q;
    cmp_d = cmp_q;
    tsel_d = tsel_q;
    mask_d = mask_q;
    if (wr) begin
      unique case (addr)
        ccpcmp_pkg::ADDR_CTRL: ctrl_d = wdata[ccpcmp_pkg::MODE_W-1:0];
        ccpcmp_pkg::ADDR_CMP_LO: cmp_d[ccpcmp_pkg::DATA_W-1:0] = wdata;
        ccpcmp_pkg::ADDR_CMP_HI: cmp_d[ccpcmp_pkg::CNT_W-1:ccpcmp_pkg::DATA_W] = wdata;
        ccpcmp_pkg::ADDR_TSEL: tsel_d = wdata[ccpcmp_pkg::TSEL_ALT];
        ccpcmp_pkg::ADDR_MASK: mask_d = wdata[ccpcmp_pkg::STAT_MATCH];
        default: ;
      endcase
    end
    match_d = match_now;

    // latch follows the match at the next clock edge
    pin_d = pin_q;
    if (ctrl_wr && wdata == ccpcmp_pkg::REG_RST) begin
      pin_d = 1'b0;
    end else if (match_edge) begin
      unique case (ctrl_q)
        ccpcmp_pkg::MODE_TOGGLE: pin_d = !pin_q;
        ccpcmp_pkg::MODE_SET: pin_d = 1'b1;
        ccpcmp_pkg::MODE_CLEAR: pin_d = 1'b0;
        default: pin_d = pin_q;
      endcase
    end
    // pin released in interrupt and trigger modes
    oe_d = (ctrl_d == ccpcmp_pkg::MODE_TOGGLE) ||
           (ctrl_d == ccpcmp_pkg::MODE_SET) ||
           (ctrl_d == ccpcmp_pkg::MODE_CLEAR);

    // flag set wins over a clear in the same cycle
    stat_d = stat_q;
    if (wr && addr == ccpcmp_pkg::ADDR_STAT && wdata[ccpcmp_pkg::STAT_MATCH]) begin
      stat_d = 1'b0;
    end
    if (match_edge) begin
      stat_d = 1'b1;
    end
    irq_d = stat_d && mask_d;

    trig_d = match_edge && (ctrl_q == ccpcmp_pkg::MODE_SPECIAL);
    adc_d = trig_d && adc_enable;
    pend_d = pend_q;
    if (trig_d) begin
      pend_d = 1'b1;
    end else if (sel_tick) begin
      pend_d = 1'b0;
    end
    // dedicated reset strobe, never the overflow path
    rsta_d = do_reset && !tsel_q;
    rstb_d = do_reset && tsel_q;

    rdata_d = ccpcmp_pkg::REG_RST;
    if (rd) begin
      unique case (addr)
        ccpcmp_pkg::ADDR_CTRL: rdata_d[ccpcmp_pkg::MODE_W-1:0] = ctrl_q;
        ccpcmp_pkg::ADDR_CMP_LO: rdata_d = cmp_q[ccpcmp_pkg::DATA_W-1:0];
        ccpcmp_pkg::ADDR_CMP_HI: rdata_d = cmp_q[ccpcmp_pkg::CNT_W-1:ccpcmp_pkg::DATA_W];
        ccpcmp_pkg::ADDR_TSEL: rdata_d[ccpcmp_pkg::TSEL_ALT] = tsel_q;
        ccpcmp_pkg::ADDR_STAT: rdata_d[ccpcmp_pkg::STAT_MATCH] = stat_q;
        ccpcmp_pkg::ADDR_MASK: rdata_d[ccpcmp_pkg::STAT_MATCH] = mask_q;
        default: rdata_d = ccpcmp_pkg::REG_RST;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= ccpcmp_pkg::MODE_OFF;
      cmp_q <= ccpcmp_pkg::CMP_RST;
      tsel_q <= 1'b0;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      match_q <= 1'b0;
      pend_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= 1'b0;
      trig_q <= 1'b0;
      adc_q <= 1'b0;
      rsta_q <= 1'b0;
      rstb_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= ccpcmp_pkg::REG_RST;
    end else begin
      ctrl_q <= ctrl_d;
      cmp_q <= cmp_d;
      tsel_q <= tsel_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      match_q <= match_d;
      pend_q <= pend_d;
      pin_q <= pin_d;
      oe_q <= oe_d;
      trig_q <= trig_d;
      adc_q <= adc_d;
      rsta_q <= rsta_d;
      rstb_q <= rstb_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign timer_a_reset = rsta_q;
  assign timer_alt_reset = rstb_q;
  assign adc_start = adc_q;
  assign compare_pin_out = pin_q;
  assign compare_pin_oe = oe_q;
  assign special_trigger = trig_q;
  assign irq = irq_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_flag_on_match: assert property (match_edge |=> stat_q)
    else $error("match flag not set");
  chk_trig_at_once: assert property (
    match_edge && ctrl_q == ccpcmp_pkg::MODE_SPECIAL |=> special_trigger)
    else $error("trigger late");
  chk_adc_with_trig: assert property (
    special_trigger |-> adc_start == $past(adc_enable))
    else $error("conversion start wrong");
  chk_adc_needs_trig: assert property (adc_start |-> special_trigger)
    else $error("conversion start without trigger");
  chk_pin_free: assert property (
    ctrl_q == ccpcmp_pkg::MODE_SWINT || ctrl_q == ccpcmp_pkg::MODE_SPECIAL
    |-> !compare_pin_oe)
    else $error("pin driven in free mode");
  chk_swint_quiet: assert property (
    match_edge && ctrl_q == ccpcmp_pkg::MODE_SWINT && !ctrl_wr
    |=> $stable(compare_pin_out) && !special_trigger)
    else $error("interrupt mode touched pin or trigger");
  chk_no_stray_trig: assert property (
    match_edge && ctrl_q != ccpcmp_pkg::MODE_SPECIAL |=> !special_trigger)
    else $error("trigger in wrong mode");
  chk_off_quiet: assert property (
    ctrl_q == ccpcmp_pkg::MODE_OFF && !ctrl_wr
    |=> $stable(compare_pin_out) && !special_trigger)
    else $error("action while unit off");

  // ==========================================
  // timer reset checks
  chk_trig_single: assert property (special_trigger |=> !special_trigger)
    else $error("trigger longer than one cycle");
  chk_reset_after_trig: assert property (
    timer_a_reset || timer_alt_reset |-> $past(pend_q) && $past(sel_tick))
    else $error("timer reset without pending trigger");
  // timer ticks never come back to back, so one strobe per trigger
  chk_reset_single: assert property (
    timer_a_reset || timer_alt_reset |=> !timer_a_reset && !timer_alt_reset)
    else $error("timer reset longer than one cycle");
  chk_reset_route: assert property (
    do_reset |=> timer_alt_reset == $past(tsel_q) && timer_a_reset == !$past(tsel_q))
    else $error("reset sent to the wrong timer");
  chk_reset_match: assert property (
    timer_a_reset || timer_alt_reset |-> $past(match_now))
    else $error("timer reset without standing match");
  chk_reset_cancel: assert property (
    pend_q && sel_tick && !match_now |=> !timer_a_reset && !timer_alt_reset)
    else $error("reset despite lost match");

  // ==========================================
  // latch, flag and bus checks
  chk_zero_clears: assert property (
    ctrl_wr && wdata == ccpcmp_pkg::REG_RST |=> !compare_pin_out && !compare_pin_oe)
    else $error("latch not cleared");
  chk_toggle_flip: assert property (
    match_edge && ctrl_q == ccpcmp_pkg::MODE_TOGGLE && !ctrl_wr
    |=> compare_pin_out != $past(compare_pin_out))
    else $error("toggle missed");
  chk_set_drives: assert property (
    match_edge && ctrl_q == ccpcmp_pkg::MODE_SET && !ctrl_wr |=> compare_pin_out)
    else $error("set missed");
  chk_clear_drives: assert property (
    match_edge && ctrl_q == ccpcmp_pkg::MODE_CLEAR |=> !compare_pin_out)
    else $error("clear missed");
  chk_latch_holds: assert property (
    !match_edge && !ctrl_wr |=> $stable(compare_pin_out))
    else $error("latch moved without a match");
  chk_sleep_idle: assert property (
    sleep_mode |=> !special_trigger && $stable(compare_pin_out))
    else $error("compare active in sleep");
  chk_flag_sticky: assert property (
    stat_q && !(wr && addr == ccpcmp_pkg::ADDR_STAT && wdata[ccpcmp_pkg::STAT_MATCH])
    |=> stat_q)
    else $error("match flag lost");
  chk_flag_clear: assert property (
    stat_q && wr && addr == ccpcmp_pkg::ADDR_STAT && wdata[ccpcmp_pkg::STAT_MATCH]
    && !match_edge |=> !stat_q)
    else $error("match flag not cleared");
  chk_irq_mask: assert property (irq == (stat_q && mask_q))
    else $error("interrupt level wrong");
  chk_read_idle: assert property (!rd |=> rdata == ccpcmp_pkg::REG_RST)
    else $error("read data outside read cycle");

  cov_toggle: cover property (match_edge && ctrl_q == ccpcmp_pkg::MODE_TOGGLE);
  cov_set_mode: cover property (match_edge && ctrl_q == ccpcmp_pkg::MODE_SET);
  cov_special_reset: cover property (trig_q ##[1:300] (rsta_q || rstb_q));
  cov_reset_cancel: cover property (pend_q && sel_tick && !match_now);
  cov_set_clear_race: cover property (match_edge && wr && addr == ccpcmp_pkg::ADDR_STAT);

endmodule : ccpcmp_top

// ===== testbench/ccpcmp_timer_model.sv
`timescale 1ns/10ps
module ccpcmp_timer_model #(
  parameter int DIV = 6,
  parameter int PHASE = 0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // count towards the unit
  input wire logic clear,
  output logic [15:0] count,
  output logic tick
);
  // ==========
  // synchronous prescaled timer
  int div_q;
  // count steps only on a tick edge; clear zeroes it at any system clock edge
  assign tick = div_q == DIV - 1;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= PHASE;
      count <= 16'h0000;
    end else begin
      div_q <= tick ? 0 : div_q + 1;
      count <= clear ? 16'h0000 : count + 16'(tick);
    end
  end
endmodule : ccpcmp_timer_model

// ===== testbench/test_ccpcmp_top.sv
`timescale 1ns/10ps
module test_ccpcmp_top;
  logic clk_sys, rst, wr, rd, adc_enable, sleep_mode;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [15:0] cnt_a, cnt_b;
  logic tick_a, tick_b, rst_a, rst_b, pin, oe, trig, adc, irq;
  int errors, compares;
  bit pin_m, mask_m, pin_dir_out;
  logic pad;
  // ==========
  // design and timers
  ccpcmp_top dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_a_count(cnt_a), .timer_a_tick(tick_a), .timer_a_reset(rst_a),
    .timer_alt_count(cnt_b), .timer_alt_tick(tick_b), .timer_alt_reset(rst_b),
    .adc_enable(adc_enable), .adc_start(adc), .sleep_mode(sleep_mode),
    .compare_pin_out(pin), .compare_pin_oe(oe), .special_trigger(trig), .irq(irq));
  ccpcmp_timer_model #(.DIV(6), .PHASE(0)) tmr_a (.clk_sys(clk_sys), .rst(rst),
    .clear(rst_a), .count(cnt_a), .tick(tick_a));
  ccpcmp_timer_model #(.DIV(6), .PHASE(3)) tmr_b (.clk_sys(clk_sys), .rst(rst),
    .clear(rst_b), .count(cnt_b), .tick(tick_b));
  // a released pin is pulled high at the pad
  assign pad = (oe && pin_dir_out) ? pin : 1'b1;
  // ==========
  // bus and checking
  task automatic bus(input bit w, input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys);
    {wr, rd} <= 2'b00;
    #1 d = rdata;
  endtask : bus
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ==========
  // one compare event; f is {alternate timer, sleep, cancel}
  task automatic run_mode(input logic [3:0] m, input bit [2:0] f);
    logic [15:0] cmp;
    logic [2:0] ev;
    int n;
    bit pin_op, hit, trg;
    cmp = (f[2] ? cnt_b : cnt_a) + 16'(6 + $urandom % 6);
    @(posedge clk_sys);
    adc_enable <= 1'($urandom);
    sleep_mode <= f[1];
    // park in a pinless mode while the compare value is half written
    bus(1'b1, ccpcmp_pkg::ADDR_CTRL, {4'h0, ccpcmp_pkg::MODE_SWINT});
    bus(1'b1, ccpcmp_pkg::ADDR_TSEL, {7'h00, f[2]});
    bus(1'b1, ccpcmp_pkg::ADDR_CMP_LO, cmp[7:0]);
    bus(1'b1, ccpcmp_pkg::ADDR_CMP_HI, cmp[15:8]);
    bus(1'b1, ccpcmp_pkg::ADDR_STAT, 8'h01);
    bus(1'b1, ccpcmp_pkg::ADDR_CTRL, {4'h0, m});
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while ((f[2] ? cnt_b : cnt_a) !== cmp && n < 200);
    @(posedge clk_sys);
    #1 hit = !f[1];
    pin_op = m inside {ccpcmp_pkg::MODE_TOGGLE, ccpcmp_pkg::MODE_SET, ccpcmp_pkg::MODE_CLEAR};
    trg = hit && m == ccpcmp_pkg::MODE_SPECIAL;
    if (hit && pin_op) begin
      pin_m = (m == ccpcmp_pkg::MODE_SET) || (m == ccpcmp_pkg::MODE_TOGGLE && !pin_m);
    end
    ev = {trg, trg & adc_enable, mask_m & hit};
    chk("pin", 16'({pin, oe}), 16'({pin_m, pin_op}));
    chk("pad", 16'(pad), 16'(pin_op ? pin_m : 1'b1));
    chk("events", 16'({trig, adc, irq}), 16'(ev));
    if (trg && f[0]) begin
      bus(1'b1, ccpcmp_pkg::ADDR_CMP_HI, ~cmp[15:8]);
      repeat (10) begin
        @(posedge clk_sys);
        #1 chk("no reset", 16'({rst_a, rst_b}), 16'h0000);
      end
    end else if (trg) begin
      n = 0;
      while (!(f[2] ? tick_b : tick_a) && n < 20) begin
        @(posedge clk_sys);
        #1 n++;
      end
      @(posedge clk_sys);
      #1 chk("reset", 16'({rst_a, rst_b}), f[2] ? 16'h0001 : 16'h0002);
    end
    bus(1'b0, ccpcmp_pkg::ADDR_STAT, 8'h00);
    chk("flag", 16'(d), 16'(hit));
    @(posedge clk_sys);
    sleep_mode <= 1'b0;
  endtask : run_mode
  // ==========
  // clock, watchdog, sequence
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    {wr, rd, adc_enable, sleep_mode, addr, wdata} = '0;
    void'($urandom(85));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      bus(1'b0, 3'(a), 8'h00);
      chk("reset value", 16'(d), 16'(ccpcmp_pkg::REG_RST));
    end
    bus(1'b1, 3'h7, 8'hff);
    bus(1'b0, 3'h7, 8'h00);
    chk("unmapped", 16'(d), 16'h0000);
    mask_m = 1'b1;
    pin_dir_out = 1'b1; // pin made an output before pin modes
    bus(1'b1, ccpcmp_pkg::ADDR_MASK, 8'h01);
    run_mode(ccpcmp_pkg::MODE_TOGGLE, 3'b000);
    run_mode(ccpcmp_pkg::MODE_CLEAR, 3'b100);
    run_mode(ccpcmp_pkg::MODE_TOGGLE, 3'b100);
    run_mode(ccpcmp_pkg::MODE_SWINT, 3'b000);
    run_mode(ccpcmp_pkg::MODE_SPECIAL, 3'b001);
    run_mode(ccpcmp_pkg::MODE_SPECIAL, 3'b100);
    mask_m = 1'b0;
    bus(1'b1, ccpcmp_pkg::ADDR_MASK, 8'h00);
    run_mode(ccpcmp_pkg::MODE_CLEAR, 3'b010);
    run_mode(ccpcmp_pkg::MODE_CLEAR, 3'b000);
    run_mode(ccpcmp_pkg::MODE_SET, 3'b100);
    bus(1'b1, ccpcmp_pkg::ADDR_CTRL, 8'h00);
    chk("cleared pin", 16'({pin, oe}), 16'h0000);
    report_and_stop();
  end
endmodule : test_ccpcmp_top
